//--- include/fbi_defs.vh
// Shared constants of the flash bus interface
`ifndef FBI_DEFS_VH
`define FBI_DEFS_VH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define FBI_DQ_W 16
`define FBI_ADDR_W 26
`define FBI_LAT_W 4
`define FBI_SYNC_STAGES 2

// ----------------------------------------------------------------------
// Burst length encodings
// ----------------------------------------------------------------------
`define FBI_BL_8 2'h0
`define FBI_BL_16 2'h1
`define FBI_BL_CONT 2'h3
`define FBI_BL_WORDS_8 5'h08
`define FBI_BL_WORDS_16 5'h10

// ----------------------------------------------------------------------
// Reset value and minimum latency of the read configuration fields
// ----------------------------------------------------------------------
`define FBI_READ_MODE_RESET 1'b1
`define FBI_MIN_LATENCY 4'h2

// ----------------------------------------------------------------------
// Pin levels seen while the host is idle
// ----------------------------------------------------------------------
`define FBI_PIN_IDLE 1'b1

`endif

//--- sim/fbi_bus_if_sva.sv
// Pin-level checker of the flash bus interface
`timescale 1ns/1ps
module fbi_bus_if_sva (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Bus pins
  input wire reset_bar,
  input wire chip_select_n,
  input wire address_valid_n,
  input wire output_enable_n,
  input wire write_strobe_n,
  input wire [25:0] addr_in,
  input wire [15:0] dq_out,
  input wire dq_oe_n,
  input wire wait_out,
  input wire wait_oe_n,
  // Configuration and internal ports
  input wire read_mode_select_bit,
  input wire wait_active_high,
  input wire [25:0] arr_addr,
  input wire [15:0] arr_data,
  input wire wr_strobe,
  input wire prog_abort
);
  wire rd_async = reset_bar & ~chip_select_n & ~output_enable_n & write_strobe_n
    & read_mode_select_bit;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reset_tri_a: assert property (!reset_bar [*4] |-> dq_oe_n && wait_oe_n)
    else $error("Outputs driven while reset pin low");
  abort_pulse_a: assert property ($fell(reset_bar) |-> ##[2:5] prog_abort)
    else $error("No abort pulse after reset pin fell");
  standby_tri_a: assert property ((reset_bar && chip_select_n) [*4] |-> dq_oe_n && wait_oe_n)
    else $error("Outputs driven in standby");
  out_disable_a: assert property ((reset_bar && !chip_select_n && output_enable_n
    && $stable(wait_active_high)) [*4] |-> dq_oe_n && !wait_oe_n && wait_out == !wait_active_high)
    else $error("Output disable state wrong");
  async_drive_a: assert property ((rd_async && $stable(wait_active_high)) [*4]
    |-> !dq_oe_n && wait_out == !wait_active_high)
    else $error("Async read not driving valid data");
  async_data_a: assert property ((rd_async && !address_valid_n && $stable(addr_in)) [*6]
    |-> arr_addr == addr_in && dq_out == $past(arr_data))
    else $error("Async read address or data wrong");
  write_fire_a: assert property ($rose(write_strobe_n) && !chip_select_n && output_enable_n
    && reset_bar |-> ##[2:4] wr_strobe)
    else $error("No write strobe after strobe pin rose");
  write_pulse_a: assert property (wr_strobe |=> !wr_strobe)
    else $error("Write strobe longer than one cycle");
  write_cause_a: assert property (wr_strobe |-> !$past(write_strobe_n, 4)
    && $past(output_enable_n, 4))
    else $error("Write strobe without a write cycle");
endmodule // fbi_bus_if_sva
bind fbi_bus_if fbi_bus_if_sva chk_u (.clk, .rst, .reset_bar, .chip_select_n, .address_valid_n,
  .output_enable_n, .write_strobe_n, .addr_in, .dq_out, .dq_oe_n, .wait_out, .wait_oe_n,
  .read_mode_select_bit, .wait_active_high, .arr_addr, .arr_data, .wr_strobe, .prog_abort);

//--- sim/fbi_host_model.sv
// Host controller model that drives the flash bus pins
`timescale 1ns/1ps
module fbi_host_model (
  // Clock
  input wire clk,
  // Control pins
  output logic reset_bar,
  output logic chip_select_n,
  output logic burst_clk,
  output logic address_valid_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  // Address and data pins
  output logic [25:0] addr_in,
  output logic [15:0] dq_in
);
  initial begin
    {reset_bar, chip_select_n, address_valid_n, output_enable_n, write_strobe_n} = 5'h1F;
    burst_clk = 1'b0;
    addr_in = 26'h0;
    dq_in = 16'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Controls as select, address valid, output enable, write strobe
  task automatic pins(input logic [3:0] c);
    {chip_select_n, address_valid_n, output_enable_n, write_strobe_n} = c;
  endtask
  task automatic set_rst(input logic v);
    reset_bar = v;
  endtask
  task automatic async_addr(input logic [25:0] a);
    addr_in = a;
    pins(4'h1);
  endtask
  task automatic adv_latch(input logic [25:0] a);
    async_addr(a);
    tick(4);
    address_valid_n = 1'b1;
    addr_in = ~a;
  endtask
  // Burst clock toggles during the data phase only when run is set
  task automatic write(input logic [25:0] a, input logic [15:0] d, input logic run);
    pins(4'hF);
    tick(2);
    addr_in = a;
    pins(4'h3);
    tick(4);
    pins(4'h7);
    addr_in = ~a;
    tick(2);
    dq_in = d;
    pins(4'h6);
    repeat (4) begin
      tick(2);
      if (run) burst_clk = ~burst_clk;
    end
    pins(4'h7);
    tick(4);
    dq_in = ~d;
    pins(4'hF);
    tick(2);
  endtask
  // Pins move after the first clock rise while address valid is still low
  task automatic burst_start(input logic [25:0] a);
    addr_in = a;
    pins(4'h1);
    #40 burst_clk = 1'b1;
    #40 addr_in = ~a;
    #40 burst_clk = 1'b0;
    #20 address_valid_n = 1'b1;
    #20;
  endtask
  task automatic bclk_cycle();
    burst_clk = 1'b1;
    #80 burst_clk = 1'b0;
    #80;
  endtask
  task automatic idle();
    pins(4'hF);
    addr_in = ~addr_in;
    tick(4);
  endtask
endmodule // fbi_host_model

//--- sim/testbench.sv
// Self-checking bench of the flash bus interface
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reset_bar, chip_select_n, burst_clk, address_valid_n, output_enable_n, write_strobe_n;
  logic [25:0] addr_in, arr_addr, wr_addr, wa, ra;
  logic [15:0] dq_in, dq_out, arr_data, wr_data, wd, rd;
  logic dq_oe_n, wait_out, wait_oe_n, wr_strobe, prog_abort;
  logic read_mode_select_bit, burst_wrap_bit, wait_active_high, nonarray_mode;
  logic [3:0] latency_count;
  logic [1:0] burst_len;
  int num_errors = 0;
  int compares = 0;
  int seed = 46536;
  int wr_cnt = 0;
  int ab_cnt = 0;
  int k;
  always #2.5 clk = ~clk;
  function automatic logic [15:0] mem(input logic [25:0] a);
    return a[15:0] ^ {6'h15, a[25:16]};
  endfunction
  assign arr_data = mem(arr_addr);
  fbi_host_model host_u (.clk, .reset_bar, .chip_select_n, .burst_clk, .address_valid_n,
    .output_enable_n, .write_strobe_n, .addr_in, .dq_in);
  fbi_bus_if dut_u (.clk, .rst, .reset_bar, .chip_select_n, .burst_clk, .address_valid_n,
    .output_enable_n, .write_strobe_n, .addr_in, .dq_in, .dq_out, .dq_oe_n, .wait_out,
    .wait_oe_n, .read_mode_select_bit, .burst_wrap_bit, .latency_count, .burst_len,
    .wait_active_high, .nonarray_mode, .arr_addr, .arr_data, .wr_strobe, .wr_addr,
    .wr_data, .prog_abort);
  always @(posedge clk) begin
    if (wr_strobe === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wa <= wr_addr;
      wd <= wr_data;
    end
    if (prog_abort === 1'b1) ab_cnt <= ab_cnt + 1;
  end
  // ----------------------------------------------------------------
  // Checking tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [25:0] e, input logic [25:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: expected %h, got %h", $time, e, g);
    end
  endtask
  task automatic chk_flag(input logic e, input logic g);
    chk_word({25'h0, e}, {25'h0, g});
  endtask
  task automatic final_report();
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Reference burst: one expectation per burst clock rise
  task automatic burst(input logic [25:0] a, input logic wr, input logic [1:0] bl,
    input logic [3:0] lat, input logic na, input logic wah, input int words, input int nr);
    logic [25:0] cur, nxt, gm;
    int i, j, due;
    logic stalled;
    {burst_wrap_bit, burst_len, latency_count, nonarray_mode} = {wr, bl, lat, na};
    wait_active_high = wah;
    read_mode_select_bit = 1'b0;
    gm = (bl == 2'h0) ? 26'h7 : 26'hF;
    cur = a;
    j = 0;
    due = lat - 1;
    stalled = 1'b0;
    host_u.burst_start(a);
    for (i = 1; i <= nr; i++) begin
      host_u.bclk_cycle();
      if (i == due && j < words) begin
        chk_word({10'h0, mem(cur)}, {10'h0, dq_out});
        chk_flag(!wah, wait_out);
        chk_flag(1'b0, dq_oe_n);
        j++;
        nxt = (wr && bl != 2'h3) ? ((cur & ~gm) | ((cur + 26'h1) & gm)) : cur + 26'h1;
        if (na) nxt = cur;
        due = i + 1;
        if (!na && !(wr && bl != 2'h3) && a[3:0] != 4'h0 && nxt[7:0] == 8'h0
            && !stalled && lat > 4'h2) begin
          due = i + lat - 1;
          stalled = 1'b1;
        end
        cur = nxt;
      end else begin
        chk_flag(wah, wait_out);
      end
    end
    host_u.idle();
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    read_mode_select_bit = 1'b1;
    {burst_wrap_bit, burst_len, latency_count, nonarray_mode, wait_active_high} = 9'($random(seed));
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    host_u.tick(3);
    for (k = 0; k < 4; k++) begin
      ra = 26'($random(seed));
      {burst_wrap_bit, burst_len, latency_count, nonarray_mode, wait_active_high} = 9'($random(seed));
      host_u.async_addr(ra);
      host_u.tick(6);
      chk_word({10'h0, mem(ra)}, {10'h0, dq_out});
      chk_flag(!wait_active_high, wait_out);
    end
    host_u.adv_latch(ra ^ 26'h155);
    host_u.tick(6);
    chk_word({10'h0, mem(ra ^ 26'h155)}, {10'h0, dq_out});
    host_u.pins(4'h7);
    host_u.tick(5);
    chk_flag(1'b1, dq_oe_n);
    chk_flag(1'b0, wait_oe_n);
    host_u.pins(4'h9);
    host_u.tick(5);
    chk_flag(1'b1, dq_oe_n);
    chk_flag(1'b1, wait_oe_n);
    chk_word(26'h0, 26'(ab_cnt));
    host_u.pins(4'h1);
    host_u.set_rst(1'b0);
    host_u.tick(6);
    chk_word(26'h1, 26'(ab_cnt));
    chk_flag(1'b1, dq_oe_n);
    host_u.set_rst(1'b1);
    host_u.tick(8);
    chk_flag(1'b0, dq_oe_n);
    for (k = 0; k < 3; k++) begin
      ra = 26'($random(seed));
      rd = 16'($random(seed));
      read_mode_select_bit = k[0];
      host_u.write(ra, rd, ~k[0]);
      chk_word(26'(k + 1), 26'(wr_cnt));
      chk_word(ra, wa);
      chk_word({10'h0, rd}, {10'h0, wd});
    end
    burst(26'h00012FA, 1'b0, 2'h0, 4'h4, 1'b0, 1'b1, 8, 16);
    burst(26'h00012FA, 1'b1, 2'h0, 4'h3, 1'b0, 1'b0, 8, 12);
    burst(26'h00003F0, 1'b0, 2'h3, 4'h2, 1'b0, 1'b1, 20, 20);
    burst(26'h0000105, 1'b0, 2'h1, 4'h5, 1'b1, 1'b1, 16, 23);
    ra = 26'($random(seed));
    burst(ra, ra[4], 2'h0, {2'h0, ra[1:0]} + 4'h2, 1'b0, ra[5], 8, 19);
    final_report();
  end
  initial begin
    #200000;
    num_errors++;
    final_report();
  end
endmodule // testbench

//--- src/fbi_burst_addr.v
// Next burst address with optional wrap inside the burst wordgroup
`timescale 1ns/1ps
`include "fbi_defs.vh"

module fbi_burst_addr #(
  parameter AW = 26,
  parameter WL_W = 8
) (
  // Current address and configuration
  input wire [AW-1:0] cur_addr,
  input wire wrap_en,
  input wire [1:0] burst_len,
  // Next address and wordline crossing flag
  output reg [AW-1:0] nxt_addr,
  output wire wl_cross
);

  wire [AW-1:0] inc_addr;

  assign inc_addr = cur_addr + {{(AW-1){1'b0}}, 1'b1};

  always @* begin
    nxt_addr = inc_addr;
    if (wrap_en && burst_len == `FBI_BL_8) begin
      nxt_addr = {cur_addr[AW-1:3], inc_addr[2:0]};
    end else if (wrap_en && burst_len == `FBI_BL_16) begin
      nxt_addr = {cur_addr[AW-1:4], inc_addr[3:0]};
    end
  end

  // A crossing is a move onto the first word of a new wordline
  assign wl_cross = (nxt_addr[WL_W-1:0] == {WL_W{1'b0}}) &&
                    (nxt_addr[AW-1:WL_W] != cur_addr[AW-1:WL_W]);

endmodule // fbi_burst_addr

//--- src/fbi_bus_if.v
// Host bus interface of a non-multiplexed address/data flash: bus state decode
`timescale 1ns/1ps
`include "fbi_defs.vh"

module fbi_bus_if #(
  parameter AW = `FBI_ADDR_W,
  parameter DW = `FBI_DQ_W,
  parameter LW = `FBI_LAT_W,
  parameter SG_W = 4,
  parameter WL_W = 8,
  parameter FAST_GRADE = 0
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Bus control pins
  input wire reset_bar,
  input wire chip_select_n,
  input wire burst_clk,
  input wire address_valid_n,
  input wire output_enable_n,
  input wire write_strobe_n,
  // Address and data pins
  input wire [AW-1:0] addr_in,
  input wire [DW-1:0] dq_in,
  output wire [DW-1:0] dq_out,
  output wire dq_oe_n,
  // Wait pin
  output wire wait_out,
  output wire wait_oe_n,
  // Read configuration register fields
  input wire read_mode_select_bit,
  input wire burst_wrap_bit,
  input wire [LW-1:0] latency_count,
  input wire [1:0] burst_len,
  input wire wait_active_high,
  // Partition read mode and array read port
  input wire nonarray_mode,
  output wire [AW-1:0] arr_addr,
  input wire [DW-1:0] arr_data,
  // Write port to the command logic
  output wire wr_strobe,
  output wire [AW-1:0] wr_addr,
  output wire [DW-1:0] wr_data,
  // Program/erase engine
  output wire prog_abort
);

  // --------------------------------------------------------------------
  // Burst states
  // --------------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_LAT = 5'h02;
  localparam [4:0] ST_DATA = 5'h04;
  localparam [4:0] ST_STALL = 5'h08;
  localparam [4:0] ST_DONE = 5'h10;
  // Number of words in a burst, zero for continuous
  function [4:0] bl_words;
    input [1:0] bl;
    begin
      case (bl)
        `FBI_BL_8: bl_words = `FBI_BL_WORDS_8;
        `FBI_BL_16: bl_words = `FBI_BL_WORDS_16;
        default: bl_words = 5'h00;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  wire rstb_s, ce_n_s, adv_n_s, oe_n_s, we_n_s, bclk_s;
  wire [AW-1:0] addr_s;
  wire [DW-1:0] dq_s;

  fbi_sync #(
    .W(6),
    .INIT(6'h3E)
  ) u_sync_ctl (
    .clk(clk),
    .rst(rst),
    .pin_in({reset_bar, chip_select_n, address_valid_n, output_enable_n,
             write_strobe_n, burst_clk}),
    .sync_out({rstb_s, ce_n_s, adv_n_s, oe_n_s, we_n_s, bclk_s})
  );

  fbi_sync #(
    .W(AW + DW),
    .INIT({(AW + DW){1'b0}})
  ) u_sync_bus (
    .clk(clk),
    .rst(rst),
    .pin_in({addr_in, dq_in}),
    .sync_out({addr_s, dq_s})
  );

  // --------------------------------------------------------------------
  // Previous samples for edge detection
  // --------------------------------------------------------------------
  reg rstb_p_q;
  reg ce_n_p_q;
  reg adv_n_p_q;
  reg we_n_p_q;
  reg bclk_p_q;
  reg [DW-1:0] dq_p_q;

  always @(posedge clk) begin
    if (rst) begin
      rstb_p_q <= `FBI_PIN_IDLE;
      ce_n_p_q <= `FBI_PIN_IDLE;
      adv_n_p_q <= `FBI_PIN_IDLE;
      we_n_p_q <= `FBI_PIN_IDLE;
      bclk_p_q <= 1'b0;
      dq_p_q <= {DW{1'b0}};
    end else begin
      rstb_p_q <= rstb_s;
      ce_n_p_q <= ce_n_s;
      adv_n_p_q <= adv_n_s;
      we_n_p_q <= we_n_s;
      bclk_p_q <= bclk_s;
      dq_p_q <= dq_s;
    end
  end

  // Device reset holds the interface idle except for the one-cycle prog_abort pulse
  wire dev_rst = rst | ~rstb_s;
  wire selected = ~ce_n_s;
  wire ce_rise = ce_n_s & ~ce_n_p_q;
  wire adv_rise = adv_n_s & ~adv_n_p_q & selected;
  wire we_rise = we_n_s & ~we_n_p_q & selected;
  wire bclk_rise = bclk_s & ~bclk_p_q;
  wire rd_sel = selected & ~oe_n_s & we_n_s;
  wire wr_sel = selected & ~we_n_s & oe_n_s;
  wire sync_rd = rd_sel & ~read_mode_select_bit;
  wire async_rd = rd_sel & read_mode_select_bit;

  // --------------------------------------------------------------------
  // Address latch: transparent while address valid is low
  // --------------------------------------------------------------------
  reg [AW-1:0] adv_addr_q;

  always @(posedge clk) begin
    if (dev_rst) begin
      adv_addr_q <= {AW{1'b0}};
    end else if (selected && !adv_n_s) begin
      adv_addr_q <= addr_s;
    end
  end

  // --------------------------------------------------------------------
  // Synchronous burst sequencer
  // --------------------------------------------------------------------
  reg [4:0] state_q;
  reg [LW-1:0] cnt_q;
  reg [4:0] words_q;
  reg [AW-1:0] bst_addr_q;
  reg misalign_q;
  reg stall_done_q;
  reg adv_taken_q;
  wire [AW-1:0] seq_addr;
  wire seq_cross;
  wire [4:0] bl_n = bl_words(burst_len);
  wire [4:0] words_inc = words_q + 5'h01;
  wire [LW-1:0] cnt_inc = cnt_q + {{(LW-1){1'b0}}, 1'b1};
  wire [LW-1:0] lat_eff = (latency_count < `FBI_MIN_LATENCY) ? `FBI_MIN_LATENCY : latency_count;
  wire wrap_on = burst_wrap_bit & (burst_len != `FBI_BL_CONT);
  wire lat_hit = (cnt_inc >= lat_eff);
  wire stall_hit = (cnt_inc >= lat_eff - {{(LW-1){1'b0}}, 1'b1});
  wire latch_clk;
  wire latch_adv;

  fbi_burst_addr #(
    .AW(AW),
    .WL_W(WL_W)
  ) u_burst_addr (
    .cur_addr(bst_addr_q),
    .wrap_en(wrap_on),
    .burst_len(burst_len),
    .nxt_addr(seq_addr),
    .wl_cross(seq_cross)
  );

  // Fast grade keeps relatching on each edge while valid is low
  assign latch_clk = sync_rd & !adv_n_s & bclk_rise &
                     ((FAST_GRADE != 0) || !adv_taken_q);
  // Slow grade also latches on the valid rising edge if no clock came
  assign latch_adv = (FAST_GRADE == 0) & sync_rd & adv_rise &
                     !adv_taken_q & (state_q == ST_IDLE);
  wire [AW-1:0] latch_addr = latch_clk ? addr_s : adv_addr_q;

  always @(posedge clk) begin
    if (dev_rst || !sync_rd) begin
      state_q <= ST_IDLE;
      cnt_q <= {LW{1'b0}};
      words_q <= 5'h00;
      bst_addr_q <= {AW{1'b0}};
      misalign_q <= 1'b0;
      stall_done_q <= 1'b0;
      adv_taken_q <= 1'b0;
    end else if (latch_clk || latch_adv) begin
      state_q <= ST_LAT;
      cnt_q <= latch_clk ? {{(LW-1){1'b0}}, 1'b1} : {LW{1'b0}};
      words_q <= 5'h00;
      bst_addr_q <= latch_addr;
      misalign_q <= (latch_addr[SG_W-1:0] != {SG_W{1'b0}});
      stall_done_q <= 1'b0;
      adv_taken_q <= 1'b1;
    end else begin
      if (adv_n_s && state_q == ST_IDLE) adv_taken_q <= 1'b0;
      if (bclk_rise) begin
        case (state_q)
          ST_IDLE: state_q <= ST_IDLE;
          ST_LAT: begin
            if (lat_hit) state_q <= ST_DATA;
            cnt_q <= cnt_inc;
          end
          ST_DATA: begin
            words_q <= words_inc;
            if (bl_n != 5'h00 && words_inc == bl_n) begin
              state_q <= ST_DONE;
            end else if (nonarray_mode) begin
              state_q <= ST_DATA;
            end else begin
              bst_addr_q <= seq_addr;
              if (seq_cross && misalign_q && !stall_done_q && lat_eff > 4'h2) begin
                state_q <= ST_STALL;
                cnt_q <= {{(LW-1){1'b0}}, 1'b1};
                stall_done_q <= 1'b1;
              end
            end
          end
          ST_STALL: begin
            if (stall_hit) state_q <= ST_DATA;
            cnt_q <= cnt_inc;
          end
          ST_DONE: state_q <= ST_DONE;
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Asynchronous write capture, clock never consulted
  // --------------------------------------------------------------------
  reg wr_addr_taken_q;
  reg [AW-1:0] wr_addr_hold_q;
  reg wr_seen_q;
  wire [AW-1:0] wr_addr_now = wr_addr_taken_q ? wr_addr_hold_q : adv_addr_q;
  wire wr_fire = wr_seen_q & (we_rise | ce_rise);

  always @(posedge clk) begin
    if (dev_rst) begin
      wr_addr_taken_q <= 1'b0;
      wr_addr_hold_q <= {AW{1'b0}};
      wr_seen_q <= 1'b0;
    end else begin
      if (!wr_addr_taken_q && (adv_rise || ce_rise)) begin
        wr_addr_hold_q <= adv_addr_q;
        wr_addr_taken_q <= 1'b1;
      end else if (ce_n_s) begin
        wr_addr_taken_q <= 1'b0;
      end
      if (wr_fire || ce_n_s) begin
        wr_seen_q <= 1'b0;
      end else if (wr_sel) begin
        wr_seen_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------
  reg [DW-1:0] dq_q;
  reg dq_oe_n_q;
  reg wait_q;
  reg wait_oe_n_q;
  reg [AW-1:0] arr_addr_q;
  reg wr_strobe_q;
  reg [AW-1:0] wr_addr_q;
  reg [DW-1:0] wr_data_q;
  reg prog_abort_q;
  reg data_bad;

  // Invalid data whenever a burst is not presenting a word
  always @* begin
    data_bad = sync_rd && (state_q != ST_DATA);
  end

  // Only the reset pin aborts; deselect leaves the engine alone
  always @(posedge clk) begin
    prog_abort_q <= ~rst & rstb_p_q & ~rstb_s;
  end

  always @(posedge clk) begin
    if (dev_rst) begin
      dq_q <= {DW{1'b0}};
      dq_oe_n_q <= 1'b1;
      wait_q <= ~wait_active_high;
      wait_oe_n_q <= 1'b1;
      arr_addr_q <= {AW{1'b0}};
      wr_strobe_q <= 1'b0;
      wr_addr_q <= {AW{1'b0}};
      wr_data_q <= {DW{1'b0}};
    end else begin
      dq_oe_n_q <= ~rd_sel;
      wait_oe_n_q <= ~selected;
      // Wait polarity follows the configuration
      wait_q <= data_bad ? wait_active_high : ~wait_active_high;
      if (async_rd) begin
        arr_addr_q <= adv_n_s ? adv_addr_q : addr_s;
      end else if (sync_rd) begin
        arr_addr_q <= bst_addr_q;
      end
      dq_q <= arr_data;
      wr_strobe_q <= wr_fire;
      if (wr_fire) begin
        wr_addr_q <= wr_addr_now;
        wr_data_q <= dq_p_q;
      end
    end
  end

  assign dq_out = dq_q;
  assign dq_oe_n = dq_oe_n_q;
  assign wait_out = wait_q;
  assign wait_oe_n = wait_oe_n_q;
  assign arr_addr = arr_addr_q;
  assign wr_strobe = wr_strobe_q;
  assign wr_addr = wr_addr_q;
  assign wr_data = wr_data_q;
  assign prog_abort = prog_abort_q;

endmodule // fbi_bus_if

//--- src/fbi_sync.v
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps

module fbi_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Pin side
  input wire [W-1:0] pin_in,
  // Clock domain side
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk) begin
    if (rst) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // fbi_sync
